// ===== hdl/hsdo_pkg.sv
package hsdo_pkg;
  // widths of the pattern path and the register port
  localparam int PAT_W = 12;
  localparam int LOW_W = 8;
  localparam int UP_W = 4;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int TAB_DEPTH = 16;
  localparam int TAB_IDX_W = 4;
  localparam int XFER_W = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_COMPARE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_COUNTER = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_EN_LOWER = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_EN_UPPER = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_OUT_LOWER = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_OUT_UPPER = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_NEXT = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_DMA_SRC = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_DMA_CNT = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_TABLE = 8'h40;

  // control register fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_DMA_EN_BIT = 1;
  localparam int CTRL_TRIG_SEL_BIT = 2;
  // status register fields; done and match are write one to clear, next valid is read only
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_MATCH_BIT = 1;
  localparam int STAT_NEXT_VALID_BIT = 2;

  // reset values
  localparam logic [CNT_W-1:0] COMPARE_RST = 16'h0000;
  localparam logic [2:0] CTRL_RST = 3'h4;
  localparam logic [PAT_W-1:0] PAT_RST = 12'h000;
  localparam logic [DATA_W-1:0] UNMAPPED_RD = 32'h0000_0000;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } hsdo_req_t;

  typedef enum logic [1:0] {
    FILL_EMPTY = 2'b00,
    FILL_ONE = 2'b01,
    FILL_FULL = 2'b10
  } hsdo_fill_t;
endpackage

// ===== hdl/hsdo_top.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - the edge counter advances once per rising edge of the external count input, not per core clock.
// - the channel A compare value resets to zero so every counted edge gives a compare match.
// - the edge counter clears when it matches the compare value and restarts counting.
// - compare A works as an output compare only and the timer drives no compare pin.
// - the edge counter ignores external edges until the start control bit is set.
// - each compare match A activates both the DMA channel and the pattern generator.
// - each DMA activation moves one pattern table entry into the next pattern register.
// - the pattern generator trigger for all twelve bits is the timer compare match.
// - a new 12-bit value appears on the pattern pins at each compare match; with compare value zero that is every detected rising edge.
// - the upper output register drives pattern bits 11 to 8 and the lower drives bits 7 to 0.
// - the upper enable register gates bits 11 to 8 and the lower enable register gates bits 7 to 0.
// - the DMA moves words sequentially, incrementing the source index, activated by compare match A.
// - the DMA writes each 12-bit word into both next pattern registers, upper and lower, and a transfer count limits the transfers.
// - a control bit enables DMA transfer and its end interrupt, raised when the last transfer is done.
module hsdo_top (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic ext_count_input,
  input wire hsdo_pkg::hsdo_req_t bus_req,
  output logic [hsdo_pkg::DATA_W-1:0] bus_rdata,
  output logic [hsdo_pkg::PAT_W-1:0] pattern_out,
  output logic [hsdo_pkg::PAT_W-1:0] pattern_out_en,
  output logic dma_done_irq
);
  import hsdo_pkg::*;

  logic ext_meta_r, ext_sync_r, ext_prev_r;
  logic [2:0] ctrl_r;
  logic [CNT_W-1:0] compare_a_value_r, edge_counter_r;
  logic [LOW_W-1:0] pattern_enable_lower_r, pattern_out_lower_r, next_pattern_lower_r;
  logic [UP_W-1:0] pattern_enable_upper_r, pattern_out_upper_r, next_pattern_upper_r;
  logic next_valid_r;
  logic [TAB_IDX_W-1:0] dma_source_addr_r;
  logic [XFER_W-1:0] dma_transfer_count_r;
  logic [1:0] dma_pend_r;
  logic done_r, match_flag_r;
  logic [PAT_W-1:0] table_r [TAB_DEPTH];
  logic [PAT_W-1:0] buf_r [2];
  logic buf_wp_r, buf_rp_r;
  hsdo_fill_t fill_r, fill_nxt;
  logic [DATA_W-1:0] rdata_nxt;

  logic ext_rise, count_edge, match_a, trig;
  logic wr_ctrl, wr_status, wr_next;
  logic fill_valid, fill_ready, fill_push;
  logic drain_valid, drain_ready, drain_pop;
  logic [PAT_W-1:0] drain_word, en_mask;

  // software port decode
  assign wr_ctrl = bus_req.wr && (bus_req.addr == OFS_CTRL);
  assign wr_status = bus_req.wr && (bus_req.addr == OFS_STATUS);
  assign wr_next = bus_req.wr && (bus_req.addr == OFS_NEXT);

  // the pin is asynchronous: two flops, then a third for the edge detect
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_meta_r <= 1'b0;
      ext_sync_r <= 1'b0;
      ext_prev_r <= 1'b0;
    end else begin
      ext_meta_r <= ext_count_input;
      ext_sync_r <= ext_meta_r;
      ext_prev_r <= ext_sync_r;
    end
  end

  assign ext_rise = ext_sync_r && !ext_prev_r;
  assign count_edge = ext_rise && ctrl_r[CTRL_START_BIT];
  assign match_a = count_edge && (edge_counter_r == compare_a_value_r);
  // match is internal only; no compare pin exists on this block
  assign trig = match_a && ctrl_r[CTRL_TRIG_SEL_BIT];

  // control and compare registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= CTRL_RST;
      compare_a_value_r <= COMPARE_RST;
    end else if (bus_req.wr) begin
      if (wr_ctrl) begin
        ctrl_r <= bus_req.wdata[2:0];
      end else if (bus_req.addr == OFS_COMPARE) begin
        compare_a_value_r <= bus_req.wdata[CNT_W-1:0];
      end
    end
  end

  // edge counter: counts only counted edges, clears on match
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      edge_counter_r <= '0;
    end else if (match_a) begin
      edge_counter_r <= '0;
    end else if (count_edge) begin
      edge_counter_r <= edge_counter_r + 16'h0001;
    end
  end

  // enables, one register per group
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pattern_enable_lower_r <= '0;
      pattern_enable_upper_r <= '0;
    end else if (bus_req.wr) begin
      if (bus_req.addr == OFS_EN_LOWER) begin
        pattern_enable_lower_r <= bus_req.wdata[LOW_W-1:0];
      end else if (bus_req.addr == OFS_EN_UPPER) begin
        pattern_enable_upper_r <= bus_req.wdata[UP_W-1:0];
      end
    end
  end

  assign en_mask = {pattern_enable_upper_r, pattern_enable_lower_r};

  // output registers: trigger copies only enabled bits; a write in the same cycle loses to the trigger
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pattern_out_lower_r <= '0;
      pattern_out_upper_r <= '0;
    end else if (trig) begin
      for (int i = 0; i < LOW_W; i++) begin
        if (pattern_enable_lower_r[i]) begin
          pattern_out_lower_r[i] <= next_pattern_lower_r[i];
        end
      end
      for (int j = 0; j < UP_W; j++) begin
        if (pattern_enable_upper_r[j]) begin
          pattern_out_upper_r[j] <= next_pattern_upper_r[j];
        end
      end
    end else if (bus_req.wr && bus_req.addr == OFS_OUT_LOWER) begin
      pattern_out_lower_r <= bus_req.wdata[LOW_W-1:0];
    end else if (bus_req.wr && bus_req.addr == OFS_OUT_UPPER) begin
      pattern_out_upper_r <= bus_req.wdata[UP_W-1:0];
    end
  end

  // pins mirror the registers one cycle later so they leave a flop
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pattern_out <= PAT_RST;
      pattern_out_en <= PAT_RST;
    end else begin
      pattern_out <= {pattern_out_upper_r, pattern_out_lower_r};
      pattern_out_en <= en_mask;
    end
  end

  // pattern table in flops, filled by software
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int k = 0; k < TAB_DEPTH; k++) begin
        table_r[k] <= PAT_RST;
      end
    end else if (bus_req.wr && bus_req.addr >= OFS_TABLE) begin
      table_r[bus_req.addr[TAB_IDX_W+1:2]] <= bus_req.wdata[PAT_W-1:0];
    end
  end

  // pending activations: a match and a fetch in one cycle cancel out
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dma_pend_r <= 2'h0;
    end else if (!ctrl_r[CTRL_DMA_EN_BIT]) begin
      dma_pend_r <= 2'h0;
    end else if (match_a && !fill_push && dma_pend_r != 2'h3) begin
      dma_pend_r <= dma_pend_r + 2'h1;
    end else if (fill_push && !match_a) begin
      dma_pend_r <= dma_pend_r - 2'h1;
    end
  end

  // the fetch stalls while the buffer is full, so no word is dropped
  assign fill_valid = ctrl_r[CTRL_DMA_EN_BIT] && (dma_pend_r != 2'h0) && (dma_transfer_count_r != '0);
  assign fill_ready = (fill_r != FILL_FULL);
  assign fill_push = fill_valid && fill_ready;

  // source index and transfer count
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dma_source_addr_r <= '0;
      dma_transfer_count_r <= '0;
    end else if (fill_push) begin
      dma_source_addr_r <= dma_source_addr_r + 4'h1;
      dma_transfer_count_r <= dma_transfer_count_r - 8'h01;
    end else if (bus_req.wr && bus_req.addr == OFS_DMA_SRC) begin
      dma_source_addr_r <= bus_req.wdata[TAB_IDX_W+1:2];
    end else if (bus_req.wr && bus_req.addr == OFS_DMA_CNT) begin
      dma_transfer_count_r <= bus_req.wdata[XFER_W-1:0];
    end
  end

  // two-entry buffer between table fetch and next pattern register
  always_comb begin
    fill_nxt = fill_r;
    if (fill_push && !drain_pop) begin
      fill_nxt = (fill_r == FILL_EMPTY) ? FILL_ONE : FILL_FULL;
    end else if (drain_pop && !fill_push) begin
      fill_nxt = (fill_r == FILL_FULL) ? FILL_ONE : FILL_EMPTY;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fill_r <= FILL_EMPTY;
      buf_wp_r <= 1'b0;
      buf_rp_r <= 1'b0;
      buf_r[0] <= PAT_RST;
      buf_r[1] <= PAT_RST;
    end else begin
      fill_r <= fill_nxt;
      if (fill_push) begin
        buf_r[buf_wp_r] <= table_r[dma_source_addr_r];
        buf_wp_r <= !buf_wp_r;
      end
      if (drain_pop) begin
        buf_rp_r <= !buf_rp_r;
      end
    end
  end

  assign drain_valid = (fill_r != FILL_EMPTY);
  assign drain_word = buf_r[buf_rp_r];
  // the slot frees on the trigger itself, so a refill may land in the same cycle
  assign drain_ready = !next_valid_r || trig;
  assign drain_pop = drain_valid && drain_ready;

  // next pattern register: the word loads upper nibble and lower byte in the same cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      next_pattern_upper_r <= '0;
      next_pattern_lower_r <= '0;
      next_valid_r <= 1'b0;
    end else if (drain_pop) begin
      {next_pattern_upper_r, next_pattern_lower_r} <= drain_word;
      next_valid_r <= 1'b1;
    end else if (wr_next) begin
      {next_pattern_upper_r, next_pattern_lower_r} <= bus_req.wdata[PAT_W-1:0];
      next_valid_r <= 1'b1;
    end else if (trig) begin
      next_valid_r <= 1'b0; // a late refill (fast strobe source) repeats old data
    end
  end

  // sticky flags; hardware set wins over a software clear
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      done_r <= 1'b0;
      match_flag_r <= 1'b0;
    end else begin
      if (fill_push && dma_transfer_count_r == 8'h01) begin
        done_r <= 1'b1;
      end else if (wr_status && bus_req.wdata[STAT_DONE_BIT]) begin
        done_r <= 1'b0;
      end
      if (match_a) begin
        match_flag_r <= 1'b1;
      end else if (wr_status && bus_req.wdata[STAT_MATCH_BIT]) begin
        match_flag_r <= 1'b0;
      end
    end
  end

  // end-of-transfer line is gated by the DMA enable bit
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dma_done_irq <= 1'b0;
    end else begin
      dma_done_irq <= done_r && ctrl_r[CTRL_DMA_EN_BIT];
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata_nxt = UNMAPPED_RD;
    if (bus_req.addr == OFS_CTRL) begin
      rdata_nxt[2:0] = ctrl_r;
    end else if (bus_req.addr == OFS_COMPARE) begin
      rdata_nxt[CNT_W-1:0] = compare_a_value_r;
    end else if (bus_req.addr == OFS_COUNTER) begin
      rdata_nxt[CNT_W-1:0] = edge_counter_r;
    end else if (bus_req.addr == OFS_EN_LOWER) begin
      rdata_nxt[LOW_W-1:0] = pattern_enable_lower_r;
    end else if (bus_req.addr == OFS_EN_UPPER) begin
      rdata_nxt[UP_W-1:0] = pattern_enable_upper_r;
    end else if (bus_req.addr == OFS_OUT_LOWER) begin
      rdata_nxt[LOW_W-1:0] = pattern_out_lower_r;
    end else if (bus_req.addr == OFS_OUT_UPPER) begin
      rdata_nxt[UP_W-1:0] = pattern_out_upper_r;
    end else if (bus_req.addr == OFS_NEXT) begin
      rdata_nxt[PAT_W-1:0] = {next_pattern_upper_r, next_pattern_lower_r};
    end else if (bus_req.addr == OFS_DMA_SRC) begin
      rdata_nxt[TAB_IDX_W+1:2] = dma_source_addr_r;
    end else if (bus_req.addr == OFS_DMA_CNT) begin
      rdata_nxt[XFER_W-1:0] = dma_transfer_count_r;
    end else if (bus_req.addr == OFS_STATUS) begin
      rdata_nxt[STAT_DONE_BIT] = done_r;
      rdata_nxt[STAT_MATCH_BIT] = match_flag_r;
      rdata_nxt[STAT_NEXT_VALID_BIT] = next_valid_r;
    end else if (bus_req.addr >= OFS_TABLE) begin
      rdata_nxt[PAT_W-1:0] = table_r[bus_req.addr[TAB_IDX_W+1:2]];
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_rdata <= '0;
    end else if (bus_req.rd) begin
      bus_rdata <= rdata_nxt;
    end else begin
      bus_rdata <= '0;
    end
  end
endmodule
`default_nettype wire

// ===== verif/hsdo_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module hsdo_top_sva (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic ext_count_input,
  input wire hsdo_pkg::hsdo_req_t bus_req,
  input wire logic [hsdo_pkg::DATA_W-1:0] bus_rdata,
  input wire logic [hsdo_pkg::PAT_W-1:0] pattern_out,
  input wire logic [hsdo_pkg::PAT_W-1:0] pattern_out_en,
  input wire logic dma_done_irq
);
  import hsdo_pkg::*;
  logic pin_q, start_q, dma_en_q, cmp_seen;
  logic [11:0] en_q;
  logic [6:0] rise_sr;
  logic [1:0] owr_sr;
  wire logic rise_w = ext_count_input & ~pin_q;
  wire logic trig_w = rise_sr[3] | rise_sr[4];
  wire logic w_w = bus_req.wr;
  wire logic [7:0] a_w = bus_req.addr;
  // shadow of software settings; sync delay is not known exactly, so triggers get a two-cycle slot
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_q <= 1'b0;
      start_q <= 1'b0;
      dma_en_q <= 1'b0;
      cmp_seen <= 1'b0;
      en_q <= '0;
      rise_sr <= '0;
      owr_sr <= '0;
    end else begin
      pin_q <= ext_count_input;
      rise_sr <= {rise_sr[5:0], rise_w};
      owr_sr <= {owr_sr[0], w_w && (a_w == OFS_OUT_LOWER || a_w == OFS_OUT_UPPER)};
      if (w_w && a_w == OFS_CTRL) begin
        start_q <= bus_req.wdata[CTRL_START_BIT];
        dma_en_q <= bus_req.wdata[CTRL_DMA_EN_BIT];
      end
      if (w_w && a_w == OFS_COMPARE) begin
        cmp_seen <= 1'b1;
      end
      if (w_w && a_w == OFS_EN_LOWER) begin
        en_q[7:0] <= bus_req.wdata[7:0];
      end
      if (w_w && a_w == OFS_EN_UPPER) begin
        en_q[11:8] <= bus_req.wdata[3:0];
      end
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  a_rdata_idle: assert property (!$past(bus_req.rd) |-> bus_rdata == '0)
    else $error("read data outside its slot");
  a_compare_reset: assert property (
    $past(bus_req.rd) && $past(bus_req.addr) == OFS_COMPARE && !cmp_seen |-> bus_rdata == DATA_W'(COMPARE_RST))
    else $error("compare value not zero after reset");
  a_change_cause: assert property ($changed(pattern_out) |-> trig_w || owr_sr != 2'b00)
    else $error("pattern changed without a strobe edge");
  a_stopped_hold: assert property (
    trig_w && !$past(start_q, 2) && owr_sr == 2'b00 |-> $stable(pattern_out))
    else $error("pattern changed while timer stopped");
  a_masked_hold: assert property (
    trig_w && owr_sr == 2'b00 |-> ((pattern_out ^ $past(pattern_out)) & ~$past(en_q, 2)) == '0)
    else $error("disabled pattern bit changed");
  a_enable_mirror: assert property (pattern_out_en == $past(en_q))
    else $error("enable mirror wrong");
  a_irq_gated: assert property (dma_done_irq |-> $past(dma_en_q))
    else $error("done interrupt while dma disabled");
  a_irq_cause: assert property ($rose(dma_done_irq) |-> |rise_sr[6:4])
    else $error("done interrupt without a transfer");
  c_trigger: cover property (trig_w && $changed(pattern_out));
  c_irq: cover property ($rose(dma_done_irq));
  c_masked: cover property (trig_w && en_q != 12'hFFF && en_q != 12'h000);
endmodule
bind hsdo_top hsdo_top_sva hsdo_top_sva_inst (.core_clk(core_clk), .arst_n(arst_n),
  .ext_count_input(ext_count_input), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .pattern_out(pattern_out), .pattern_out_en(pattern_out_en), .dma_done_irq(dma_done_irq));
`default_nettype wire

// ===== verif/hsdo_strobe_src.sv
`timescale 1ns/1ps
`default_nettype none
module hsdo_strobe_src (
  input wire logic core_clk,
  input wire logic [hsdo_pkg::PAT_W-1:0] pattern_out,
  output logic strobe,
  output logic [hsdo_pkg::PAT_W-1:0] rx_word
);
  import hsdo_pkg::*;
  // strobe idles low between edges
  initial begin
    strobe = 1'b0;
    rx_word = '0;
  end
  // one edge, then a low gap long enough for the refill before the next edge
  task automatic pulse(input int hi, input int lo);
    @(posedge core_clk);
    strobe <= 1'b1;
    repeat (hi) @(posedge core_clk);
    strobe <= 1'b0;
    repeat (lo) @(posedge core_clk);
    #1;
    rx_word = pattern_out;
  endtask
endmodule
`default_nettype wire

// ===== verif/hsdo_bench.sv
`timescale 1ns/1ps
`default_nettype none
module hsdo_bench;
  import hsdo_pkg::*;
  logic core_clk, arst_n, strobe, irq;
  hsdo_req_t req;
  logic [DATA_W-1:0] rdata;
  logic [PAT_W-1:0] pat, pat_en, rx;
  int mismatches, checks_done;
  hsdo_top hsdo_top_inst (.core_clk(core_clk), .arst_n(arst_n), .ext_count_input(strobe), .bus_req(req),
    .bus_rdata(rdata), .pattern_out(pat), .pattern_out_en(pat_en), .dma_done_irq(irq));
  hsdo_strobe_src hsdo_strobe_src_inst (.core_clk(core_clk), .pattern_out(pat), .strobe(strobe), .rx_word(rx));
  function automatic logic [11:0] tv(input int i);
    return 12'h0A5 + 12'(12'h111 * i);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge core_clk);
    req.wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge core_clk);
    req.rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic fire(input logic [11:0] exp);
    hsdo_strobe_src_inst.pulse(3, 8);
    chk(32'(rx), 32'(exp));
  endtask
  task automatic stop_test;
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    stop_test();
  end
  initial begin
    arst_n = 1'b0;
    req = '0;
    mismatches = 0;
    checks_done = 0;
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(OFS_CTRL, 32'(CTRL_RST));
    rd(OFS_COMPARE, 32'h0000_0000);
    rd(8'h30, UNMAPPED_RD);
    for (int i = 0; i < TAB_DEPTH; i++) begin
      wr(OFS_TABLE + 8'(4 * i), 32'(tv(i)));
    end
    wr(OFS_EN_LOWER, 32'h0000_00FF);
    wr(OFS_EN_UPPER, 32'h0000_000F);
    wr(OFS_NEXT, 32'h0000_05A3);
    fire(12'h000);
    rd(OFS_COUNTER, 32'h0000_0000);
    // three refills from the table start, then the count runs out
    wr(OFS_DMA_SRC, 32'h0000_0000);
    wr(OFS_DMA_CNT, 32'h0000_0003);
    wr(OFS_CTRL, 32'h0000_0007);
    fire(12'h5A3);
    fire(tv(0));
    fire(tv(1));
    chk(32'(irq), 32'h0000_0001);
    rd(OFS_COUNTER, 32'h0000_0000);
    fire(tv(2));
    fire(tv(2));
    wr(OFS_CTRL, 32'h0000_0005);
    repeat (2) @(posedge core_clk);
    #1;
    chk(32'(irq), 32'h0000_0000);
    rd(OFS_STATUS, 32'h0000_0003);
    wr(OFS_STATUS, 32'h0000_0003);
    rd(OFS_STATUS, 32'h0000_0000);
    wr(OFS_OUT_UPPER, 32'h0000_000F);
    wr(OFS_OUT_LOWER, 32'h0000_003C);
    @(posedge core_clk);
    #1;
    chk(32'(pat), 32'h0000_0F3C);
    // only the low nibble is enabled
    wr(OFS_EN_UPPER, 32'h0000_0000);
    wr(OFS_EN_LOWER, 32'h0000_000F);
    wr(OFS_NEXT, 32'h0000_0AAA);
    fire(12'hF3A);
    chk(32'(pat_en), 32'h0000_000F);
    // compare of two: two plain counts, then a match that clears
    wr(OFS_EN_UPPER, 32'h0000_000F);
    wr(OFS_EN_LOWER, 32'h0000_00FF);
    wr(OFS_COMPARE, 32'h0000_0002);
    wr(OFS_NEXT, 32'h0000_0123);
    fire(12'hF3A);
    fire(12'hF3A);
    rd(OFS_COUNTER, 32'h0000_0002);
    fire(12'h123);
    rd(OFS_COUNTER, 32'h0000_0000);
    // trigger select off: the match still counts but the pins keep their value
    wr(OFS_CTRL, 32'h0000_0001);
    wr(OFS_COMPARE, 32'h0000_0000);
    wr(OFS_NEXT, 32'h0000_0456);
    fire(12'h123);
    rd(OFS_STATUS, 32'h0000_0006);
    stop_test();
  end
endmodule
`default_nettype wire
